// [include/stream_log_pkg.sv]
// constants shared by the stream and queued error log recorder
// assumes a byte-addressed 512-byte log image read one byte at a time
package stream_log_pkg;
	// log addresses selected by the log read session
	localparam logic [7:0] LOG_QUEUED       = 8'h10;
	localparam logic [7:0] LOG_WRITE_STREAM = 8'h21;
	localparam logic [7:0] LOG_READ_STREAM  = 8'h22;
	// stream log header layout
	localparam logic [7:0] STRUCT_VERSION = 8'h02;
	localparam logic [8:0] HDR_VERSION    = 9'h000;
	localparam logic [8:0] HDR_INDEX      = 9'h001;
	localparam logic [8:0] HDR_COUNT_LO   = 9'h002;
	localparam logic [8:0] HDR_COUNT_HI   = 9'h003;
	localparam logic [8:0] ENTRY_BASE     = 9'h010;
	localparam int         ENTRY_BYTES    = 16;
	localparam int         MAX_ENTRIES    = 31;
	// entry byte positions
	localparam int ENT_FEAT_CUR  = 0;
	localparam int ENT_FEAT_PREV = 1;
	localparam int ENT_STATUS    = 2;
	localparam int ENT_ERROR     = 3;
	localparam int ENT_LBA       = 4;
	localparam int ENT_COUNT     = 12;
	localparam logic [7:0] DEFERRED_FEATURE = 8'hFF;
	// stream counters and index
	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
	localparam logic [4:0]  INDEX_EMPTY = 5'h00;
	localparam logic [4:0]  INDEX_FIRST = 5'h01;
	localparam logic [4:0]  INDEX_LAST  = 5'h1F;
	// queued error record layout
	localparam int         Q_REC_BYTES = 14;
	localparam int         Q_TAG_W     = 5;
	localparam int         Q_NQ_BIT    = 7;
	localparam logic [8:0] Q_CHECKSUM  = 9'h1FF;
	// log read session
	typedef enum logic {SESS_IDLE, SESS_OPEN} session_type;
endpackage

// [hw/byte_checksum.sv]
// two's complement checksum over a flat vector of bytes
// assumes bytes not in the vector are zero and so add nothing
`timescale 1ns/10ps
module byte_checksum #(
	parameter int NBYTES = 14
) (
	input  wire logic [8*NBYTES-1:0] bytesIn,
	output logic      [7:0]          checkOut
);
	logic [7:0] sum;

	// modulo 256 sum, then negate so the whole image sums to zero
	always_comb begin
		sum = 8'h00;
		for (int i = 0; i < NBYTES; i++) begin
			sum = sum + bytesIn[8*i +: 8];
		end
		checkOut = 8'h00 - sum;
	end
endmodule

// [hw/stream_error_log.sv]
// one stream error log: entry ring, newest index, saturating count
// assumes append and clear are one-cycle pulses on mclk
`timescale 1ns/10ps
module stream_error_log #(
	parameter int DEPTH = stream_log_pkg::MAX_ENTRIES
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        clear,
	input  wire logic        append,
	input  wire logic [127:0] entryIn,
	input  wire logic [8:0]  rdAddr,
	output logic      [7:0]  rdByte,
	output logic      [4:0]  index_reg,
	output logic      [15:0] count_reg
);
	localparam logic [4:0] LAST = 5'(DEPTH);

	logic [127:0] ent_reg [DEPTH];
	logic [4:0]   index_next;
	logic [4:0]   slot;
	logic [4:0]   entNum;

	// newest index wraps over the oldest once the ring is full
	always_comb begin
		if (clear || index_reg == LAST) begin
			index_next = stream_log_pkg::INDEX_FIRST;
		end else begin
			index_next = index_reg + 5'h01;
		end
		slot = index_next - 5'h01;
	end

	// index: an append in the clearing cycle survives the clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			index_reg <= stream_log_pkg::INDEX_EMPTY;
		end else if (append) begin
			index_reg <= index_next;
		end else if (clear) begin
			index_reg <= stream_log_pkg::INDEX_EMPTY;
		end
	end

	// count runs well past the ring depth, saturates at FFFFh and never wraps
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= 16'h0000;
		end else if (append) begin
			if (clear) begin
				count_reg <= 16'h0001;
			end else if (count_reg != stream_log_pkg::COUNT_MAX) begin
				count_reg <= count_reg + 16'h0001;
			end
		end else if (clear) begin
			count_reg <= 16'h0000;
		end
	end

	// entry ring: clear empties it, the new entry lands at the newest slot
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				ent_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (append && slot == 5'(i)) begin
					ent_reg[i] <= entryIn;
				end else if (clear) begin
					ent_reg[i] <= '0;
				end
			end
		end
	end

	// log image: header, reserved gap, then 16-byte entries
	always_comb begin
		entNum = rdAddr[8:4];
		rdByte = 8'h00;
		if (rdAddr == stream_log_pkg::HDR_VERSION) begin
			rdByte = stream_log_pkg::STRUCT_VERSION;
		end else if (rdAddr == stream_log_pkg::HDR_INDEX) begin
			rdByte = {3'h0, index_reg};
		end else if (rdAddr == stream_log_pkg::HDR_COUNT_LO) begin
			rdByte = count_reg[7:0];
		end else if (rdAddr == stream_log_pkg::HDR_COUNT_HI) begin
			rdByte = count_reg[15:8];
		end else if (rdAddr >= stream_log_pkg::ENTRY_BASE &&
				entNum <= LAST) begin
			rdByte = ent_reg[entNum - 5'h01][8*rdAddr[3:0] +: 8];
		end
	end
endmodule

// [hw/stream_error_log_recorder.sv]
// error log recorder: queued error record plus read and write stream logs
// assumes all inputs come from logic on mclk; events are one-cycle pulses
//
// Overview of operation
// - with the non-queued flag clear, byte 0 bits 4-0 hold the failing tag.
// - byte 0 bit 7 is set for a non-queued error, clear for a queued one.
// - bytes 1 to 13 copy the shadow register block at error report.
// - byte 511 makes all 512 queued log bytes sum to zero modulo 256.
// - only a failure with the stream error flag set adds a stream entry.
// - each stream log keeps at most 31 entries, the most recent ones.
// - read stream count totals errors since the last good read of log 22h.
// - the two-byte stream error count saturates and never wraps.
// - a good read of log 22h zeroes read stream index and count.
// - power-on and hardware reset leave both stream logs empty.
// - stream image is version, index, count, reserved, entries at 10h-1F0h.
// - the stream log version byte always reads 02h.
// - the read stream index names the newest entry, from 1 to 31.
// - entry holds features, status, error, address at 04h, count at 0Ch.
// - a deferred write error stores all ones in both feature bytes.
// - an entry spans a sector range: first failing address and length.
// - the write stream log works alike, cleared by a good read of 21h.
// - the write stream count restarts at reset and after a good read of the log.
// - the write stream index names the newest entry, from 1 to 31.
`timescale 1ns/10ps
module stream_error_log_recorder (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic         qErrValid,
	input  wire logic         nonQueuedFlag,
	input  wire logic [4:0]   qErrTag,
	input  wire logic [103:0] shadowBlock,
	input  wire logic         strErrValid,
	input  wire logic         strErrWrite,
	input  wire logic         streamErrorFlag,
	input  wire logic         deferredWrite,
	input  wire logic [7:0]   featCur,
	input  wire logic [7:0]   featPrev,
	input  wire logic [7:0]   statusReg,
	input  wire logic [7:0]   errorReg,
	input  wire logic [47:0]  errLba,
	input  wire logic [15:0]  errSectors,
	input  wire logic         logOpen,
	input  wire logic [7:0]   logSelect,
	input  wire logic         byteReq,
	input  wire logic [8:0]   byteAddr,
	input  wire logic         logClose,
	input  wire logic         closeOk,
	output logic              byteValid_reg,
	output logic      [7:0]   byteData_reg,
	output logic              sessionOpen_reg,
	output logic              qLogValid_reg,
	output logic      [4:0]   readStreamIndex,
	output logic      [15:0]  readStreamCount,
	output logic      [4:0]   writeStreamIndex,
	output logic      [15:0]  writeStreamCount
);
	localparam int QB = stream_log_pkg::Q_REC_BYTES;

	stream_log_pkg::session_type sess_reg;
	logic [7:0]      sel_reg;
	logic [8*QB-1:0] qRec_reg;
	logic [8*QB-1:0] qRec_next;
	logic [7:0]      qCheck_reg;
	logic [7:0]      qCheck_next;
	logic [127:0]    entry;
	logic            appendRd;
	logic            appendWr;
	logic            closeGood;
	logic            clearRd;
	logic            clearWr;
	logic [7:0]      rdByteRs;
	logic [7:0]      rdByteWs;
	logic [7:0]      qByte;
	logic [7:0]      qSum;

	////////////////////////////////////////////////////////////////////////
	// queued error record

	// byte 0 carries the flag and tag, then the shadow block verbatim
	always_comb begin
		qRec_next = '0;
		qRec_next[stream_log_pkg::Q_NQ_BIT] = nonQueuedFlag;
		if (!nonQueuedFlag) begin
			qRec_next[stream_log_pkg::Q_TAG_W-1:0] = qErrTag;
		end
		qRec_next[8*QB-1:8] = shadowBlock;
	end

	// checksum over the new record; reserved bytes add nothing
	byte_checksum #(
		.NBYTES (QB)
	) u_qcheck (
		.bytesIn  (qRec_next),
		.checkOut (qCheck_next)
	);

	// record and checksum load together so they never disagree
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			qRec_reg      <= '0;
			qCheck_reg    <= 8'h00;
			qLogValid_reg <= 1'b0;
		end else if (qErrValid) begin
			qRec_reg      <= qRec_next;
			qCheck_reg    <= qCheck_next;
			qLogValid_reg <= 1'b1;
		end
	end

	// queued log image byte
	always_comb begin
		qByte = 8'h00;
		if (byteAddr < 9'(QB)) begin
			qByte = qRec_reg[8*byteAddr[3:0] +: 8];
		end else if (byteAddr == stream_log_pkg::Q_CHECKSUM) begin
			qByte = qCheck_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stream entry capture

	// one entry layout serves both stream logs
	always_comb begin
		entry = '0;
		entry[8*stream_log_pkg::ENT_FEAT_CUR +: 8]  = featCur;
		entry[8*stream_log_pkg::ENT_FEAT_PREV +: 8] = featPrev;
		if (deferredWrite) begin
			entry[8*stream_log_pkg::ENT_FEAT_CUR +: 8] =
				stream_log_pkg::DEFERRED_FEATURE;
			entry[8*stream_log_pkg::ENT_FEAT_PREV +: 8] =
				stream_log_pkg::DEFERRED_FEATURE;
		end
		entry[8*stream_log_pkg::ENT_STATUS +: 8] = statusReg;
		entry[8*stream_log_pkg::ENT_ERROR +: 8]  = errorReg;
		entry[8*stream_log_pkg::ENT_LBA +: 48]   = errLba;
		entry[8*stream_log_pkg::ENT_COUNT +: 16] = errSectors;
	end

	// failures without the stream error flag never reach a log
	assign appendRd = strErrValid && streamErrorFlag && !strErrWrite;
	assign appendWr = strErrValid && streamErrorFlag && strErrWrite;

	////////////////////////////////////////////////////////////////////////
	// log read session

	// only a session closed with success clears the stream log it addressed; the queued log is never cleared
	assign closeGood = logClose && closeOk &&
		sess_reg == stream_log_pkg::SESS_OPEN;
	assign clearRd = closeGood &&
		sel_reg == stream_log_pkg::LOG_READ_STREAM;
	assign clearWr = closeGood &&
		sel_reg == stream_log_pkg::LOG_WRITE_STREAM;

	// session state; an open while already open is ignored
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sess_reg <= stream_log_pkg::SESS_IDLE;
			sel_reg  <= 8'h00;
		end else begin
			case (sess_reg)
				stream_log_pkg::SESS_IDLE: begin
					if (logOpen) begin
						sess_reg <= stream_log_pkg::SESS_OPEN;
						sel_reg  <= logSelect;
					end
				end
				stream_log_pkg::SESS_OPEN: begin
					if (logClose) begin
						sess_reg <= stream_log_pkg::SESS_IDLE;
					end
				end
				default: begin
					sess_reg <= stream_log_pkg::SESS_IDLE;
				end
			endcase
		end
	end

	// session flag for the host side; follows the session state, but an open and a close in one idle cycle leave it low
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sessionOpen_reg <= 1'b0;
		end else if (logClose) begin
			sessionOpen_reg <= 1'b0;
		end else if (logOpen) begin
			sessionOpen_reg <= 1'b1;
		end
	end

	// byte answer one cycle after the request; unknown logs read zero
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			byteValid_reg <= 1'b0;
			byteData_reg  <= 8'h00;
		end else begin
			byteValid_reg <= byteReq && sess_reg == stream_log_pkg::SESS_OPEN;
			if (byteReq && sess_reg == stream_log_pkg::SESS_OPEN) begin
				case (sel_reg)
					stream_log_pkg::LOG_READ_STREAM: byteData_reg <= rdByteRs;
					stream_log_pkg::LOG_WRITE_STREAM: byteData_reg <= rdByteWs;
					stream_log_pkg::LOG_QUEUED: byteData_reg <= qByte;
					default: byteData_reg <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// the two stream logs

	stream_error_log #(
		.DEPTH (stream_log_pkg::MAX_ENTRIES)
	) u_read_log (
		.mclk      (mclk),
		.rstn      (rstn),
		.clear     (clearRd),
		.append    (appendRd),
		.entryIn   (entry),
		.rdAddr    (byteAddr),
		.rdByte    (rdByteRs),
		.index_reg (readStreamIndex),
		.count_reg (readStreamCount)
	);

	stream_error_log #(
		.DEPTH (stream_log_pkg::MAX_ENTRIES)
	) u_write_log (
		.mclk      (mclk),
		.rstn      (rstn),
		.clear     (clearWr),
		.append    (appendWr),
		.entryIn   (entry),
		.rdAddr    (byteAddr),
		.rdByte    (rdByteWs),
		.index_reg (writeStreamIndex),
		.count_reg (writeStreamCount)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	// helper: whole queued record plus checksum, modulo 256
	always_comb begin
		qSum = qCheck_reg;
		for (int i = 0; i < QB; i++) begin
			qSum = qSum + qRec_reg[8*i +: 8];
		end
	end

	a_queued_tag: assert property (@(posedge mclk) disable iff (!rstn)
		qErrValid && !nonQueuedFlag |=> qRec_reg[4:0] == $past(qErrTag))
		else $error("queued tag not captured");

	a_nq_bit: assert property (@(posedge mclk) disable iff (!rstn)
		qErrValid |=> qRec_reg[7] == $past(nonQueuedFlag))
		else $error("non-queued bit wrong");

	a_shadow_copy: assert property (@(posedge mclk) disable iff (!rstn)
		qErrValid |=> qRec_reg[111:8] == $past(shadowBlock))
		else $error("shadow block not captured");

	a_checksum_zero: assert property (@(posedge mclk) disable iff (!rstn)
		qLogValid_reg |-> qSum == 8'h00)
		else $error("queued log does not sum to zero");

	a_flag_gates_entry: assert property (@(posedge mclk)
		disable iff (!rstn)
		strErrValid && !streamErrorFlag && !clearRd
		|=> $stable(readStreamCount) && $stable(readStreamIndex))
		else $error("entry added without stream error flag");

	a_count_tracks: assert property (@(posedge mclk) disable iff (!rstn)
		appendRd && !clearRd && readStreamCount != 16'hFFFF
		|=> readStreamCount == $past(readStreamCount) + 16'h0001)
		else $error("read stream count did not advance");

	a_count_saturates: assert property (@(posedge mclk)
		disable iff (!rstn)
		readStreamCount == 16'hFFFF && !clearRd
		|=> readStreamCount == 16'hFFFF)
		else $error("read stream count wrapped");

	a_clear_read: assert property (@(posedge mclk) disable iff (!rstn)
		clearRd && !appendRd |=> readStreamIndex == 5'h00 &&
		readStreamCount == 16'h0000)
		else $error("read stream log not cleared");

	a_clear_write: assert property (@(posedge mclk) disable iff (!rstn)
		clearWr && !appendWr |=> writeStreamIndex == 5'h00 &&
		writeStreamCount == 16'h0000)
		else $error("write stream log not cleared");

	a_version_byte: assert property (@(posedge mclk) disable iff (!rstn)
		byteReq && sess_reg == stream_log_pkg::SESS_OPEN &&
		byteAddr == 9'h000 && sel_reg == stream_log_pkg::LOG_READ_STREAM
		|=> byteValid_reg && byteData_reg == 8'h02)
		else $error("version byte not 02h");

	a_index_range: assert property (@(posedge mclk) disable iff (!rstn)
		readStreamCount != 16'h0000
		|-> readStreamIndex >= 5'h01 && readStreamIndex <= 5'h1F)
		else $error("read stream index out of range");

	a_index_wraps: assert property (@(posedge mclk) disable iff (!rstn)
		appendWr && !clearWr && writeStreamIndex == 5'h1F
		|=> writeStreamIndex == 5'h01)
		else $error("write stream index did not wrap");
endmodule

// [verif/host_log_reader.sv]
// host side of the log read session: open, byte reads, close
// assumes the recorder answers a byte request one cycle after it
`timescale 1ns/10ps
module host_log_reader (
	input  wire logic       mclk,
	input  wire logic       byteValid,
	input  wire logic [7:0] byteData,
	output logic            logOpen,
	output logic      [7:0] logSelect,
	output logic            byteReq,
	output logic      [8:0] byteAddr,
	output logic            logClose,
	output logic            closeOk
);
	logic gotValid;

	////////////////////////////////////////////////////////////////////////
	// idle levels at time zero
	initial begin
		logOpen = 1'b0;
		logSelect = 8'h00;
		byteReq = 1'b0;
		byteAddr = 9'h000;
		logClose = 1'b0;
		closeOk = 1'b0;
		gotValid = 1'b0;
	end

	// released lines flip so a stale value is never mistaken for a live one
	task automatic open_log(input logic [7:0] sel);
		@(negedge mclk);
		logOpen = 1'b1;
		logSelect = sel;
		@(negedge mclk);
		logOpen = 1'b0;
		logSelect = ~sel;
	endtask

	// answer taken at the falling edge while the one-cycle pulse stands;
	// a cycle later the valid pulse is already gone
	task automatic read_byte(input logic [8:0] a, output logic [7:0] d);
		@(negedge mclk);
		byteReq = 1'b1;
		byteAddr = a;
		@(negedge mclk);
		gotValid = byteValid;
		d = byteData;
		byteReq = 1'b0;
		byteAddr = ~a;
	endtask

	// closeOk low models a read that ended in error
	task automatic close_log(input logic ok);
		@(negedge mclk);
		logClose = 1'b1;
		closeOk = ok;
		@(negedge mclk);
		logClose = 1'b0;
		closeOk = ~ok;
	endtask
endmodule

// [verif/tb_stream_error_log_recorder.sv]
// self-checking bench for the error log recorder
// assumes host_log_reader drives the read session side
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch at %0t got %h expected %h", $time, g, e); end end
module tb_stream_error_log_recorder;
	logic         mclk, rstn, qErrValid, nonQueuedFlag;
	logic [4:0]   qErrTag;
	logic [103:0] shadowBlock;
	logic         strErrValid, strErrWrite, streamErrorFlag, deferredWrite;
	logic [7:0]   featCur, featPrev, statusReg, errorReg, logSelect;
	logic [47:0]  errLba;
	logic [15:0]  errSectors;
	logic         logOpen, byteReq, logClose, closeOk;
	logic [8:0]   byteAddr;
	logic         byteValid_reg, sessionOpen_reg, qLogValid_reg;
	logic [7:0]   byteData_reg;
	logic [4:0]   readStreamIndex, writeStreamIndex;
	logic [15:0]  readStreamCount, writeStreamCount;
	int           n_mismatch, cmp_count, cycles;

	stream_error_log_recorder u_dut (.mclk, .rstn, .qErrValid,
		.nonQueuedFlag, .qErrTag, .shadowBlock, .strErrValid, .strErrWrite,
		.streamErrorFlag, .deferredWrite, .featCur, .featPrev, .statusReg,
		.errorReg, .errLba, .errSectors, .logOpen, .logSelect, .byteReq,
		.byteAddr, .logClose, .closeOk, .byteValid_reg, .byteData_reg,
		.sessionOpen_reg, .qLogValid_reg, .readStreamIndex,
		.readStreamCount, .writeStreamIndex, .writeStreamCount);

	host_log_reader u_host (.mclk, .byteValid(byteValid_reg),
		.byteData(byteData_reg), .logOpen, .logSelect, .byteReq,
		.byteAddr, .logClose, .closeOk);

	////////////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// hang guard: the saturation run alone needs about 66k cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 80000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.read_byte(a, d);
		`CHK(u_host.gotValid, 1'b1)
		`CHK(d, e)
	endtask

	// stream failure held for n back-to-back cycles
	task automatic push(input logic wr, fl, df, input logic [7:0] fc,
			input int n);
		@(negedge mclk);
		strErrValid = 1'b1;
		strErrWrite = wr;
		streamErrorFlag = fl;
		deferredWrite = df;
		featCur = fc;
		repeat (n) @(negedge mclk);
		strErrValid = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_empty();
		`CHK(readStreamIndex, 5'h00)
		`CHK(readStreamCount, 16'h0000)
		`CHK(writeStreamIndex, 5'h00)
		`CHK(writeStreamCount, 16'h0000)
	endtask

	// checksum worked out here: byte 0 plus the 13 shadow bytes, negated
	// a new tag and a rotated shadow block for every capture
	task automatic t_queued(input logic nq, input logic [4:0] tg,
			input logic [7:0] b0);
		logic [7:0] s;
		@(negedge mclk);
		qErrValid = 1'b1;
		nonQueuedFlag = nq;
		qErrTag = tg;
		shadowBlock = {shadowBlock[95:0], shadowBlock[103:96]};
		@(negedge mclk);
		qErrValid = 1'b0;
		`CHK(qLogValid_reg, 1'b1)
		s = b0;
		for (int k = 0; k < 13; k++)
			s = s + shadowBlock[8*k +: 8];
		u_host.open_log(8'h10);
		rd_chk(9'h000, b0);
		rd_chk(9'h001, shadowBlock[7:0]);
		rd_chk(9'h00D, shadowBlock[103:96]);
		rd_chk(9'h00E, 8'h00);
		rd_chk(9'h1FF, 8'h00 - s);
		u_host.close_log(1'b1);
	endtask

	// flag clear must not add an entry
	task automatic t_noflag();
		push(1'b0, 1'b0, 1'b0, 8'h3C, 3);
		push(1'b1, 1'b0, 1'b0, 8'h3C, 2);
		t_empty();
	endtask

	// one entry, image layout, then a failed read that must not clear
	task automatic t_entry();
		push(1'b0, 1'b1, 1'b0, 8'h3C, 1);
		`CHK(readStreamIndex, 5'h01)
		`CHK(readStreamCount, 16'h0001)
		u_host.open_log(8'h22);
		`CHK(sessionOpen_reg, 1'b1)
		rd_chk(9'h000, 8'h02);
		rd_chk(9'h001, 8'h01);
		rd_chk(9'h002, 8'h01);
		rd_chk(9'h003, 8'h00);
		rd_chk(9'h00F, 8'h00);
		rd_chk(9'h010, 8'h3C);
		rd_chk(9'h011, featPrev);
		rd_chk(9'h012, statusReg);
		rd_chk(9'h013, errorReg);
		rd_chk(9'h014, errLba[7:0]);
		rd_chk(9'h019, errLba[47:40]);
		rd_chk(9'h01A, 8'h00);
		rd_chk(9'h01C, errSectors[7:0]);
		rd_chk(9'h01D, errSectors[15:8]);
		u_host.close_log(1'b0);
		`CHK(sessionOpen_reg, 1'b0)
		`CHK(readStreamIndex, 5'h01)
		`CHK(readStreamCount, 16'h0001)
	endtask

	// deferred write entry in the write log, then a good read of 21h
	task automatic t_write();
		push(1'b1, 1'b1, 1'b1, 8'h3C, 1);
		`CHK(writeStreamIndex, 5'h01)
		`CHK(writeStreamCount, 16'h0001)
		u_host.open_log(8'h21);
		rd_chk(9'h000, 8'h02);
		rd_chk(9'h010, 8'hFF);
		rd_chk(9'h011, 8'hFF);
		u_host.close_log(1'b1);
		`CHK(writeStreamIndex, 5'h00)
		`CHK(writeStreamCount, 16'h0000)
		`CHK(readStreamIndex, 5'h01)
	endtask

	// fill to 31, one more overwrites the oldest slot
	task automatic t_wrap();
		push(1'b0, 1'b1, 1'b0, 8'h11, 30);
		`CHK(readStreamIndex, 5'h1F)
		errLba = 48'hFEDCBA987654;
		push(1'b0, 1'b1, 1'b0, 8'h5A, 1);
		`CHK(readStreamIndex, 5'h01)
		`CHK(readStreamCount, 16'h0020)
		u_host.open_log(8'h22);
		rd_chk(9'h010, 8'h5A);
		rd_chk(9'h014, 8'h54);
		rd_chk(9'h020, 8'h11);
		rd_chk(9'h1F0, 8'h11);
		u_host.close_log(1'b1);
		`CHK(readStreamIndex, 5'h00)
		`CHK(readStreamCount, 16'h0000)
	endtask

	// 65537 errors from empty: count pins at FFFFh, index at 3
	task automatic t_sat();
		push(1'b0, 1'b1, 1'b0, 8'h11, 65535);
		`CHK(readStreamCount, 16'hFFFF)
		push(1'b0, 1'b1, 1'b0, 8'h11, 2);
		`CHK(readStreamCount, 16'hFFFF)
		`CHK(readStreamIndex, 5'h03)
		push(1'b1, 1'b1, 1'b0, 8'h11, 32);
		`CHK(writeStreamIndex, 5'h01)
		`CHK(writeStreamCount, 16'h0020)
		@(negedge mclk);
		rstn = 1'b0;
		@(negedge mclk);
		rstn = 1'b1;
		t_empty();
		`CHK(qLogValid_reg, 1'b0)
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence; status, error, previous features and length stay fixed
	initial begin
		{n_mismatch, cmp_count, cycles} = '0;
		rstn = 1'b0;
		{qErrValid, nonQueuedFlag, strErrValid, strErrWrite} = '0;
		{streamErrorFlag, deferredWrite} = '0;
		qErrTag = 5'h15;
		shadowBlock = 104'hF1E2D3C4B5A6978879695A4B3C;
		featCur = 8'h3C;
		featPrev = 8'hA5;
		statusReg = 8'h51;
		errorReg = 8'h40;
		errLba = 48'h123456789ABC;
		errSectors = 16'h0208;
		repeat (5) @(negedge mclk);
		rstn = 1'b1;
		t_empty();
		t_queued(1'b0, 5'h15, 8'h15);
		t_queued(1'b1, 5'h0A, 8'h80);
		t_noflag();
		t_entry();
		t_write();
		t_wrap();
		t_sat();
		stop_test();
	end
endmodule
